// ==== hdl/rsc_params.svh ====
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ==========================================
// Timing
`define RSC_CLK_NS       40
`define RSC_ROM_ACK_NS   300
`define RSC_REG_ACK_NS   600
`define RSC_ROM_ACK_CYC  ((`RSC_ROM_ACK_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_REG_ACK_CYC  ((`RSC_REG_ACK_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_ACK_PRELOAD  2
`define RSC_CNT_W        8

// ==========================================
// ROM map: base of each map as a 2K-byte slot, and row order per slot (per slot pair in the 8K map)
`define RSC_SLOT_I       5'h18
`define RSC_SLOT_II      5'h14
`define RSC_SLOT_III     5'h10
`define RSC_SLOTS_4K     5'h04
`define RSC_SLOTS_8K     5'h08
`define RSC_ORDER_4K     8'h72
`define RSC_ORDER_8K     8'h4E

// ==========================================
// Register addresses
`define RSC_MASK_ADDR    16'hFFB2
`define RSC_SENSE_ADDR   16'hFFB0
`define RSC_SER_BASE     13'h1FEE
`define RSC_SER_RXBUF    2'h1
`define RSC_SENSE_LSB    4
`define RSC_OVR_HI       15
`define RSC_OVR_LO       14

// ==========================================
// Trap vectors
`define RSC_VEC_0        8'h60
`define RSC_VEC_1        8'h64
`define RSC_VEC_2        8'h30
`define RSC_VEC_3        8'h34
`define RSC_VEC_4        8'h68
`define RSC_VEC_5        8'h6C
`define RSC_VEC_6        8'h40
`define RSC_VEC_7        8'h70
`define RSC_VEC_LINK     8'h78

`endif

// ==== hdl/rsc_pkg.sv ====
package rsc_pkg;

    typedef enum logic [1:0] {
        MAP_I   = 2'h0,
        MAP_II  = 2'h1,
        MAP_III = 2'h2,
        MAP_OFF = 2'h3
    } rsc_map_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ROM  = 2'h1,
        ST_DONE = 2'h3,
        ST_REG  = 2'h2
    } rsc_state_e;

    typedef enum logic [1:0] {
        TGT_NONE   = 2'h0,
        TGT_MASK   = 2'h1,
        TGT_SENSE  = 2'h2,
        TGT_SERIAL = 2'h3
    } rsc_tgt_e;

    typedef struct packed {
        logic [15:0] addr;
        logic        byte_mode;
    } rsc_req_s;

    typedef struct packed {
        logic pen_sw2;
        logic pen_sw1;
        logic byte_pair;
        logic refresh_halted;
    } rsc_sense_s;

    typedef struct packed {
        logic [2:0] code;
        logic       link;
    } rsc_trap_s;

endpackage

// ==== hdl/rsc_decoder.sv ====
`include "rsc_params.svh"
`timescale 1ns/1ps
`default_nettype none
// Operation
// - ROM range read hit raises ROM enable and one of four 2K-word row reads.
// - Never more than one row read enable active at a time.
// - Each row is four 4-bit devices forming one 16-bit word.
// - ROM accesses acknowledge 300 ns after selection.
// - Mask and sense accesses acknowledge 600 ns after selection.
// - Low select enables low-byte devices; otherwise only high byte drives.
// - High select set routes ROM high byte onto low output lines.
// - High select only when byte mode and address bit 0 are both set.
// - Upper drive low places ROM high byte on upper bus lines.
// - Receive buffer read reports overrun on bus bits 15 and 14.
// - Low output gates pass the internal output bus low byte.
// - Trap vector is an 8-bit word chosen per nine conditions.
// - Bus low byte always passes inverted onto internal input bus.
// - Map I places rows 2,0,3,1 at octal 140000 to 157777.
// - Map II places rows 2,0,3,1 at octal 120000 to 137777.
// - Map III places rows 2,3,0,1 at octal 100000 to 137777.
// - Register group decodes mask read/write, sense read, serial enable.
// - Serial enable selects the addressed serial register.
// - Mask write loads from input bus; mask read returns stored value.
// - Read at octal 177660 returns the four sense bits.
module rsc_decoder #(
    parameter int ROW_WORDS = 2048
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             arst_n_i,
    // Jumper strap
    input  wire rsc_pkg::rsc_map_e map_sel_i,
    // Processor bus
    input  wire rsc_pkg::rsc_req_s req_i,
    input  wire logic             bus_rd_i,
    input  wire logic             bus_wr_i,
    input  wire logic [15:0]      bus_data_n_i,
    output logic      [15:0]      bus_data_n_o,
    output logic      [1:0]       bus_data_oe_o,
    output logic                  mem_ack_o,
    // ROM strobes
    output logic                  rom_range_enable_o,
    output logic      [3:0]       row_read_n_o,
    output logic                  low_byte_select_n_o,
    output logic                  upper_byte_drive_n_o,
    // Register group
    output logic                  register_group_enable_o,
    output logic                  mask_write_n_o,
    output logic                  mask_read_n_o,
    output logic                  sense_read_n_o,
    output logic      [7:0]       mask_o,
    input  wire rsc_pkg::rsc_sense_s sense_i,
    // Serial port
    output logic                  serial_regs_enable_o,
    output logic      [1:0]       serial_sel_o,
    output logic                  serial_write_o,
    output logic                  rx_buffer_read_n_o,
    output logic      [7:0]       internal_in_bus_o,
    input  wire logic [7:0]       serial_rdata_i,
    input  wire logic             rx_overrun_n_i,
    // Interrupt vector
    input  wire logic             vector_read_i,
    input  wire rsc_pkg::rsc_trap_s trap_i,
    // ROM loading
    input  wire logic             rom_load_we_i,
    input  wire logic [1:0]       rom_load_row_i,
    input  wire logic [10:0]      rom_load_addr_i,
    input  wire logic [15:0]      rom_load_data_i
);
    import rsc_pkg::*;

    localparam int ROM_CYC = `RSC_ROM_ACK_CYC;
    localparam int REG_CYC = `RSC_REG_ACK_CYC;

    // ==========================================
    // Decoding functions
    function automatic logic [2:0] rom_decode(rsc_map_e m, logic [15:0] a);
        logic [4:0] off;
        logic [2:0] res;
        off = 5'h00;
        res = 3'h0;
        case (m)
            MAP_I: begin
                off = a[15:11] - `RSC_SLOT_I;
                res = {off < `RSC_SLOTS_4K, 2'(`RSC_ORDER_4K >> {off[1:0], 1'b0})};
            end
            MAP_II: begin
                off = a[15:11] - `RSC_SLOT_II;
                res = {off < `RSC_SLOTS_4K, 2'(`RSC_ORDER_4K >> {off[1:0], 1'b0})};
            end
            MAP_III: begin
                off = a[15:11] - `RSC_SLOT_III;
                res = {off < `RSC_SLOTS_8K, 2'(`RSC_ORDER_8K >> {off[2:1], 1'b0})};
            end
            default: res = 3'h0;
        endcase
        return res;
    endfunction

    function automatic rsc_tgt_e reg_decode(logic [15:0] a);
        rsc_tgt_e t;
        t = TGT_NONE;
        if (a == `RSC_MASK_ADDR) begin
            t = TGT_MASK;
        end else if (a == `RSC_SENSE_ADDR) begin
            t = TGT_SENSE;
        end else if (a[15:3] == `RSC_SER_BASE) begin
            t = TGT_SERIAL;
        end
        return t;
    endfunction

    function automatic logic [7:0] trap_vector(rsc_trap_s t);
        logic [7:0] v;
        v = `RSC_VEC_LINK;
        if (!t.link) begin
            case (t.code)
                3'h0:    v = `RSC_VEC_0;
                3'h1:    v = `RSC_VEC_1;
                3'h2:    v = `RSC_VEC_2;
                3'h3:    v = `RSC_VEC_3;
                3'h4:    v = `RSC_VEC_4;
                3'h5:    v = `RSC_VEC_5;
                3'h6:    v = `RSC_VEC_6;
                default: v = `RSC_VEC_7;
            endcase
        end
        return v;
    endfunction

    // ==========================================
    // Jumper strap
    // The strap is caught after reset release; until then no ROM row is mapped.
    rsc_map_e cfg_r;
    rsc_map_e cfg_nxt;
    logic     cfg_ok_r;
    logic     cfg_ok_nxt;

    always_comb begin
        cfg_nxt    = cfg_ok_r ? cfg_r : map_sel_i;
        cfg_ok_nxt = 1'b1;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_r    <= MAP_OFF;
            cfg_ok_r <= 1'b0;
        end else begin
            cfg_r    <= cfg_nxt;
            cfg_ok_r <= cfg_ok_nxt;
        end
    end

    // ==========================================
    // Request decode
    logic [2:0]  rom_dec;
    logic        rom_hit;
    rsc_tgt_e    tgt;
    logic [10:0] word_addr;
    logic [7:0]  internal_in_bus;

    assign rom_dec         = rom_decode(cfg_r, req_i.addr);
    assign rom_hit         = rom_dec[2];
    assign tgt             = reg_decode(req_i.addr);
    assign word_addr       = (cfg_r == MAP_III) ? req_i.addr[11:1] : {1'b0, req_i.addr[10:1]};
    assign internal_in_bus = ~bus_data_n_i[7:0];
    assign internal_in_bus_o = internal_in_bus;

    // ==========================================
    // ROM rows
    logic               rom_go;
    logic [3:0][15:0]   rom_q;

    for (genvar r = 0; r < 4; r++) begin : g_row
        for (genvar n = 0; n < 4; n++) begin : g_dev
            logic [3:0] mem [ROW_WORDS];
            logic [3:0] q_r;
            always_ff @(posedge clk_sys_i) begin
                if (rom_load_we_i && rom_load_row_i == 2'(r)) begin
                    mem[rom_load_addr_i] <= rom_load_data_i[n*4 +: 4];
                end
                if (rom_go) begin
                    q_r <= mem[word_addr];
                end
            end
            assign rom_q[r][n*4 +: 4] = q_r;
        end
    end

    // ==========================================
    // Access sequencer
    rsc_state_e           st_r;
    rsc_state_e           st_nxt;
    logic [`RSC_CNT_W-1:0] cnt_r;
    logic [`RSC_CNT_W-1:0] cnt_nxt;
    logic [1:0]           row_r;
    logic [1:0]           row_nxt;
    logic                 hi_r;
    logic                 hi_nxt;
    logic                 byte_r;
    logic                 byte_nxt;
    logic                 rd_r;
    logic                 rd_nxt;
    rsc_tgt_e             tgt_r;
    rsc_tgt_e             tgt_nxt;
    logic [1:0]           sel_r;
    logic [1:0]           sel_nxt;
    logic [15:0]          word_r;
    logic [15:0]          word_nxt;
    logic [1:0]           lane_r;
    logic [1:0]           lane_nxt;
    logic                 vec_r;
    logic                 vec_nxt;
    logic                 mwr_r;
    logic                 mwr_nxt;
    logic                 swr_r;
    logic                 swr_nxt;
    logic [7:0]           mask_r;
    logic [7:0]           mask_nxt;
    logic                 idle;

    assign idle   = (st_r == ST_IDLE);
    assign rom_go = idle && bus_rd_i && rom_hit;

    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        row_nxt  = row_r;
        hi_nxt   = hi_r;
        byte_nxt = byte_r;
        rd_nxt   = rd_r;
        tgt_nxt  = tgt_r;
        sel_nxt  = sel_r;
        word_nxt = word_r;
        lane_nxt = lane_r;
        vec_nxt  = 1'b0;
        mwr_nxt  = 1'b0;
        swr_nxt  = 1'b0;
        mask_nxt = mask_r;
        case (st_r)
            ST_IDLE: begin
                tgt_nxt  = TGT_NONE;
                lane_nxt = 2'b00;
                rd_nxt   = bus_rd_i;
                sel_nxt  = req_i.addr[2:1];
                if ((bus_rd_i || bus_wr_i) && rom_hit) begin
                    st_nxt   = ST_ROM;
                    cnt_nxt  = `RSC_CNT_W'(ROM_CYC - `RSC_ACK_PRELOAD);
                    row_nxt  = rom_dec[1:0];
                    byte_nxt = req_i.byte_mode;
                    hi_nxt   = req_i.byte_mode && req_i.addr[0];
                    lane_nxt = bus_rd_i ? {~req_i.byte_mode, 1'b1} : 2'b00;
                end else if ((bus_rd_i || bus_wr_i) && tgt != TGT_NONE) begin
                    st_nxt   = ST_REG;
                    cnt_nxt  = `RSC_CNT_W'(REG_CYC - `RSC_ACK_PRELOAD);
                    tgt_nxt  = tgt;
                    word_nxt = 16'h0000;
                    lane_nxt = {1'b0, bus_rd_i};
                    case (tgt)
                        TGT_MASK: begin
                            word_nxt[7:0] = mask_r;
                            mwr_nxt       = bus_wr_i;
                            if (bus_wr_i) begin
                                mask_nxt = internal_in_bus;
                            end
                        end
                        TGT_SENSE: begin
                            word_nxt[`RSC_SENSE_LSB +: 4] = sense_i;
                            lane_nxt = {1'b0, bus_rd_i};
                        end
                        TGT_SERIAL: begin
                            word_nxt[7:0] = serial_rdata_i;
                            swr_nxt       = bus_wr_i;
                            if (bus_rd_i && req_i.addr[2:1] == `RSC_SER_RXBUF) begin
                                word_nxt[`RSC_OVR_HI] = ~rx_overrun_n_i;
                                word_nxt[`RSC_OVR_LO] = ~rx_overrun_n_i;
                                lane_nxt = 2'b11;
                            end
                        end
                        default: word_nxt = 16'h0000;
                    endcase
                end else if (vector_read_i) begin
                    vec_nxt  = 1'b1;
                    word_nxt = {8'h00, trap_vector(trap_i)};
                    lane_nxt = 2'b01;
                end
            end
            ST_ROM, ST_REG: begin
                if (cnt_r == `RSC_CNT_W'(0)) begin
                    st_nxt = ST_DONE;
                end else begin
                    cnt_nxt = cnt_r - `RSC_CNT_W'(1);
                end
            end
            ST_DONE: begin
                st_nxt   = ST_IDLE;
                lane_nxt = 2'b00;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r   <= ST_IDLE;
            cnt_r  <= '0;
            row_r  <= 2'h0;
            hi_r   <= 1'b0;
            byte_r <= 1'b0;
            rd_r   <= 1'b0;
            tgt_r  <= TGT_NONE;
            sel_r  <= 2'h0;
            word_r <= 16'h0000;
            lane_r <= 2'b00;
            vec_r  <= 1'b0;
            mwr_r  <= 1'b0;
            swr_r  <= 1'b0;
            mask_r <= 8'h00;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            row_r  <= row_nxt;
            hi_r   <= hi_nxt;
            byte_r <= byte_nxt;
            rd_r   <= rd_nxt;
            tgt_r  <= tgt_nxt;
            sel_r  <= sel_nxt;
            word_r <= word_nxt;
            lane_r <= lane_nxt;
            vec_r  <= vec_nxt;
            mwr_r  <= mwr_nxt;
            swr_r  <= swr_nxt;
            mask_r <= mask_nxt;
        end
    end

    // ==========================================
    // Strobes and data gates
    // The ROM path muxes registered device outputs, so word data stand
    // from the cycle after the strobe without a second pipeline stage.
    logic        rom_act;
    logic        reg_act;
    logic [15:0] rom_word;
    logic [15:0] internal_out_bus;

    assign rom_act  = (st_r == ST_ROM) || (st_r == ST_DONE && tgt_r == TGT_NONE);
    assign reg_act  = (st_r == ST_REG) || (st_r == ST_DONE && tgt_r != TGT_NONE);
    assign rom_word = rom_q[row_r];

    always_comb begin
        internal_out_bus = word_r;
        if (rom_act) begin
            internal_out_bus[7:0]  = hi_r ? rom_word[15:8] : rom_word[7:0];
            internal_out_bus[15:8] = rom_word[15:8];
        end
    end

    assign bus_data_n_o         = ~internal_out_bus;
    assign bus_data_oe_o        = lane_r;
    assign mem_ack_o            = (st_r == ST_DONE);
    assign rom_range_enable_o   = rom_act && rd_r;
    assign row_read_n_o         = ~({3'b000, rom_range_enable_o} << row_r);
    assign low_byte_select_n_o  = ~(rom_range_enable_o && !hi_r);
    assign upper_byte_drive_n_o = ~(rom_range_enable_o && !byte_r);
    assign register_group_enable_o = reg_act;
    assign mask_write_n_o       = ~mwr_r;
    assign mask_read_n_o        = ~(reg_act && rd_r && tgt_r == TGT_MASK);
    assign sense_read_n_o       = ~(reg_act && rd_r && tgt_r == TGT_SENSE);
    assign mask_o               = mask_r;
    assign serial_regs_enable_o = reg_act && tgt_r == TGT_SERIAL;
    assign serial_sel_o         = sel_r;
    assign serial_write_o       = swr_r;
    assign rx_buffer_read_n_o   = ~(serial_regs_enable_o && rd_r && sel_r == `RSC_SER_RXBUF);

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    a_row_onehot: assert property ($onehot0(~row_read_n_o))
        else $error("more than one ROM row enabled");
    a_rom_rows: assert property (rom_range_enable_o |-> $onehot(~row_read_n_o))
        else $error("ROM enabled without exactly one row");
    a_rom_ack: assert property (rom_go |-> !mem_ack_o [*8] ##1 mem_ack_o)
        else $error("ROM acknowledge delay wrong");
    a_reg_ack: assert property ((idle && bus_rd_i && !rom_hit && tgt != TGT_NONE)
        |-> ##15 mem_ack_o)
        else $error("register acknowledge delay wrong");
    a_byte_route: assert property ((rom_go && req_i.byte_mode && req_i.addr[0])
        |=> low_byte_select_n_o && upper_byte_drive_n_o
            && bus_data_n_o[7:0] == ~rom_word[15:8])
        else $error("odd byte not routed to low lines");
    a_upper_drive: assert property (!upper_byte_drive_n_o
        |-> bus_data_oe_o == 2'b11 && bus_data_n_o[15:8] == ~rom_word[15:8])
        else $error("upper lines not carrying ROM high byte");
    a_overrun_bits: assert property ((idle && bus_rd_i && !rom_hit && tgt == TGT_SERIAL
        && req_i.addr[2:1] == `RSC_SER_RXBUF)
        |=> bus_data_n_o[15:14] == {2{$past(rx_overrun_n_i)}})
        else $error("overrun state not on bits 15 and 14");
    a_mask_load: assert property ((idle && bus_wr_i && !rom_hit && tgt == TGT_MASK)
        |=> mask_o == ~$past(bus_data_n_i[7:0]))
        else $error("mask not loaded from inverted bus byte");
    a_mask_read: assert property ((idle && bus_rd_i && !rom_hit && tgt == TGT_MASK)
        |=> bus_data_n_o[7:0] == ~mask_o && !mask_read_n_o)
        else $error("mask read returns wrong value");
    a_sense_read: assert property ((idle && bus_rd_i && !rom_hit && tgt == TGT_SENSE)
        |=> !sense_read_n_o && bus_data_n_o[7:4] == ~$past(sense_i))
        else $error("sense word wrong");
    a_unmapped: assert property ((idle && (bus_rd_i || bus_wr_i) && !rom_hit
        && tgt == TGT_NONE && !vector_read_i)
        |=> (!mem_ack_o && bus_data_oe_o == 2'b00 && &row_read_n_o) [*2])
        else $error("card answered an unmapped access");

    c_rom_word: cover property (rom_go && !req_i.byte_mode ##8 mem_ack_o);
    c_rom_byte: cover property (rom_go && req_i.byte_mode && req_i.addr[0]);
    c_mask_wr:  cover property (!mask_write_n_o);
    c_vector:   cover property (vec_r);

endmodule // rsc_decoder
`default_nettype wire

// ==== verification/rsc_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bus master model
// A data line released by the master shows the inverse of its last value.
module rsc_master_model (
    // Clock
    input  wire logic        clk_i,
    // Answer from the card
    input  wire logic        ack_i,
    input  wire logic [15:0] data_n_i,
    // Request toward the card
    output var rsc_pkg::rsc_req_s req_o,
    output logic             rd_o,
    output logic             wr_o,
    output logic [15:0]      data_n_o
);
    import rsc_pkg::*;

    initial begin
        req_o = '0;
        rd_o = 1'b0;
        wr_o = 1'b0;
        data_n_o = 16'hFFFF;
    end

    // One strobe cycle, then wait for the acknowledge; lat stays 20 if none came.
    task automatic xfer(input logic [15:0] a, input logic bm, input logic w,
                        input logic [7:0] wd, output logic [15:0] rd, output int lat);
        @(posedge clk_i);
        req_o <= '{addr: a, byte_mode: bm};
        rd_o <= !w;
        wr_o <= w;
        data_n_o <= {8'hFF, ~wd};
        @(posedge clk_i);
        rd_o <= 1'b0;
        wr_o <= 1'b0;
        data_n_o <= {8'h00, wd};
        lat = 20;
        rd = 16'h0000;
        for (int n = 1; n < 20; n++) begin
            @(negedge clk_i);
            if (ack_i === 1'b1) begin
                rd = ~data_n_i;
                lat = n;
                break;
            end
            @(posedge clk_i);
        end
    endtask
endmodule // rsc_master_model
`default_nettype wire

// ==== verification/rom_status_card_decoder_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module rom_status_card_decoder_bench;
    import rsc_pkg::*;

    logic        clk_sys_i;
    logic        arst_n_i;
    rsc_map_e    map_sel;
    rsc_req_s    req;
    logic        rd;
    logic        wr;
    logic [15:0] din_n;
    logic [15:0] dout_n;
    logic [1:0]  oe;
    logic        ack;
    logic [3:0]  row_n;
    logic [7:0]  mask;
    logic [7:0]  in_bus;
    rsc_sense_s  sense;
    logic [7:0]  ser_data;
    logic        ovr_n;
    logic        vec_rd;
    rsc_trap_s   trap;
    logic        ld_we;
    logic [1:0]  ld_row;
    logic        rom_en, low_byte_select_n_n, ubd_n, reg_en, mrd_n, srd_n, ser_en, rxb_n;
    int          fail_count;
    int          checks_done;
    int          cycles;
    logic [7:0]  vec_exp [9] = '{8'h60, 8'h64, 8'h30, 8'h34, 8'h68, 8'h6C, 8'h40, 8'h70,
                                  8'h78};

    rsc_master_model i_master (.clk_i(clk_sys_i), .ack_i(ack), .data_n_i(dout_n),
        .req_o(req), .rd_o(rd), .wr_o(wr), .data_n_o(din_n));

    rsc_decoder i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .map_sel_i(map_sel),
        .req_i(req), .bus_rd_i(rd), .bus_wr_i(wr), .bus_data_n_i(din_n),
        .bus_data_n_o(dout_n), .bus_data_oe_o(oe), .mem_ack_o(ack),
        .rom_range_enable_o(rom_en), .row_read_n_o(row_n), .low_byte_select_n_o(low_byte_select_n_n),
        .upper_byte_drive_n_o(ubd_n), .register_group_enable_o(reg_en), .mask_write_n_o(),
        .mask_read_n_o(mrd_n), .sense_read_n_o(srd_n), .mask_o(mask), .sense_i(sense),
        .serial_regs_enable_o(ser_en), .serial_sel_o(), .serial_write_o(),
        .rx_buffer_read_n_o(rxb_n), .internal_in_bus_o(in_bus), .serial_rdata_i(ser_data),
        .rx_overrun_n_i(ovr_n), .vector_read_i(vec_rd), .trap_i(trap),
        .rom_load_we_i(ld_we), .rom_load_row_i(ld_row), .rom_load_addr_i(11'h000),
        .rom_load_data_i(rw(ld_row)));

    // ==========================================
    // Helpers
    function automatic logic [15:0] rw(input logic [1:0] r);
        return {8'h60 + 8'(r), 8'h90 + 8'(r)};
    endfunction

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic summarize();
        if (fail_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The strap is only taken after a reset, so each map gets its own reset.
    task automatic do_reset(input rsc_map_e m);
        arst_n_i <= 1'b0;
        map_sel <= m;
        repeat (10) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
    endtask

    // ==========================================
    // Scenarios
    task automatic rom_rows(input logic [15:0] base, input logic [15:0] step,
                            input logic [7:0] order);
        logic [15:0] d;
        int          lat;
        logic [1:0]  r;
        for (int i = 0; i < 4; i++) begin
            r = order[2*i +: 2];
            i_master.xfer(base + step * 16'(i), 1'b0, 1'b0, 8'h00, d, lat);
            chk("rom word", rw(r), d);
            chk("row enables", {12'h000, ~(4'h1 << r)}, {12'h000, row_n});
            chk("rom lanes", 16'h0003, {14'h0, oe});
            chk("rom strobes", 16'h0004, {13'h0, rom_en, low_byte_select_n_n, ubd_n});
            chk("rom ack", 16'h0008, 16'(lat));
        end
    endtask

    task automatic byte_reads();
        logic [15:0] d;
        logic [15:0] e;
        int          lat;
        e = rw(2'd2);
        i_master.xfer(16'hC000, 1'b1, 1'b0, 8'h00, d, lat);
        chk("even byte", {8'h00, e[7:0]}, {8'h00, d[7:0]});
        chk("even lanes", 16'h0001, {14'h0, oe});
        chk("even strobes", 16'h0005, {13'h0, rom_en, low_byte_select_n_n, ubd_n});
        i_master.xfer(16'hC001, 1'b1, 1'b0, 8'h00, d, lat);
        chk("odd byte", {8'h00, e[15:8]}, {8'h00, d[7:0]});
        chk("odd lanes", 16'h0001, {14'h0, oe});
        chk("odd strobes", 16'h0007, {13'h0, rom_en, low_byte_select_n_n, ubd_n});
    endtask

    task automatic regs();
        logic [15:0] d;
        int          lat;
        i_master.xfer(16'hFFB2, 1'b0, 1'b1, 8'h5A, d, lat);
        chk("mask ack", 16'd15, 16'(lat));
        chk("mask stored", 16'h005A, {8'h00, mask});
        chk("input bus", 16'h00A5, {8'h00, in_bus});
        i_master.xfer(16'hFFB2, 1'b0, 1'b0, 8'h00, d, lat);
        chk("mask read", 16'h005A, {8'h00, d[7:0]});
        chk("mask strobes", 16'h0005, {13'h0, reg_en, mrd_n, srd_n});
        sense <= rsc_sense_s'(4'hA);
        i_master.xfer(16'hFFB0, 1'b0, 1'b0, 8'h00, d, lat);
        chk("sense read", 16'h00A0, {8'h00, d[7:4], 4'h0});
        chk("sense ack", 16'd15, 16'(lat));
        chk("sense strobes", 16'h0006, {13'h0, reg_en, mrd_n, srd_n});
        ovr_n <= 1'b0;
        ser_data <= 8'h3C;
        i_master.xfer(16'hFF72, 1'b0, 1'b0, 8'h00, d, lat);
        chk("rx buffer", 16'hC03C, d);
        chk("serial strobes", 16'h0002, {14'h0, ser_en, rxb_n});
        i_master.xfer(16'h0000, 1'b0, 1'b0, 8'h00, d, lat);
        chk("unmapped ack", 16'd20, 16'(lat));
        chk("unmapped lanes", 16'h0000, {14'h0, oe});
        chk("unmapped enables", 16'h0000, {13'h0, rom_en, reg_en, ser_en});
    endtask

    task automatic vectors();
        for (int k = 0; k < 9; k++) begin
            @(posedge clk_sys_i);
            trap <= '{code: 3'(k), link: (k == 8)};
            vec_rd <= 1'b1;
            @(posedge clk_sys_i);
            vec_rd <= 1'b0;
            @(negedge clk_sys_i);
            chk("trap vector", {8'h00, vec_exp[k]}, {8'h00, ~dout_n[7:0]});
            chk("vector lanes", 16'h0001, {14'h0, oe});
        end
    endtask

    // ==========================================
    // Clock, watchdog and main sequence
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        arst_n_i = 1'b0;
        map_sel = MAP_I;
        sense = '0;
        ser_data = 8'h00;
        ovr_n = 1'b1;
        vec_rd = 1'b0;
        trap = '0;
        ld_we = 1'b0;
        ld_row = 2'd0;
        do_reset(MAP_I);
        for (int r = 0; r < 4; r++) begin
            ld_we <= 1'b1;
            ld_row <= 2'(r);
            @(posedge clk_sys_i);
        end
        ld_we <= 1'b0;
        rom_rows(16'hC000, 16'h0800, 8'h72);
        byte_reads();
        regs();
        vectors();
        do_reset(MAP_II);
        rom_rows(16'hA000, 16'h0800, 8'h72);
        do_reset(MAP_III);
        rom_rows(16'h8000, 16'h1000, 8'h4E);
        summarize();
    end
endmodule // rom_status_card_decoder_bench
`default_nettype wire
